// *** pviu_bench.sv ***
// testbench: host models feed both links, reference model checks the last group sent before each wait
module pviu_bench
    import pviu_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk_sys, srst, strap, uv, iv, nv, route_wr;
    logic [31:0] ul, ur, il, ir;
    pviu_chan_t  nat;
    logic [2:0]  route_dest;
    logic [4:0]  route_src;
    logic [31:0] outs [4];
    logic [3:0]  pv;
    logic        w24, umute, imute, uerr, ierr;
    logic [31:0] au [4], uexp [4], iexp [4], nexp [4];
    int          route [4];
    int          fails = 0, cmp_count = 0, vcnt = 0, ecnt = 0, icnt = 0, v0, e0;

    pviu_host_model #(.WIDTH(24)) i_host_usb (.clk_sys(clk_sys), .frame_valid(uv),
        .left(ul), .right(ur));
    pviu_host_model #(.WIDTH(32)) i_host_i2s (.clk_sys(clk_sys), .frame_valid(iv),
        .left(il), .right(ir));

    pviu_top i_pviu_top (
        .clk_sys(clk_sys), .srst(srst), .usb_width_24_strap(strap),
        .usb_frame_valid(uv), .usb_left(ul), .usb_right(ur),
        .i2s_frame_valid(iv), .i2s_left(il), .i2s_right(ir),
        .native_valid(nv), .native_sample(nat),
        .route_wr(route_wr), .route_dest(route_dest), .route_src(route_src),
        .pipeline_microphone_in_0(outs[0]), .pipeline_microphone_in_1(outs[1]),
        .pipeline_reference_in_0(outs[2]), .pipeline_reference_in_1(outs[3]),
        .pipeline_valid(pv), .usb_width_24(w24), .usb_muted(umute), .i2s_muted(imute),
        .usb_marker_error(uerr), .i2s_marker_error(ierr)
    );

    // clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // count valid pulses on slot 0 and marker errors of both links
    always @(posedge clk_sys) begin
        if (pv[0] === 1'b1) vcnt++;
        if (uerr === 1'b1) ecnt++;
        if (ierr === 1'b1) icnt++;
    end

    // watchdog
    initial begin
        #200000;
        fails++;
        report_and_stop();
    end

    // ========
    // reference model and checking
    function automatic logic [31:0] aud(input logic [31:0] raw, input int w);
        logic [31:0] msk;
        msk = (w == 32) ? 32'hFFFFFFFF : ((32'h1 << w) - 32'h1);
        return ((raw & msk) >> 1) << (33 - w);
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // writes slot routes back to back, then one ignored write to destination 0
    task automatic set_routes(input int s [4]);
        for (int d = 4; d < 9; d++) begin
            route_wr   = 1'b1;
            route_dest = d[2:0];
            route_src  = (d == 8) ? 5'h12 : 5'(s[d[1:0]]);
            @(posedge clk_sys);
            #1;
        end
        route_wr = 1'b0;
        route    = s;
    endtask

    task automatic grp(input bit i2s, input bit rz, input bit hold, input int bad);
        for (int k = 0; k < 4; k++) au[k] = (rz && k > 1) ? 32'h0 : $urandom;
        if (i2s) begin
            i_host_i2s.send_group(au, bad, hold);
            for (int k = 0; k < 4; k++) iexp[k] = aud(i_host_i2s.sent[k], 32);
        end else begin
            i_host_usb.send_group(au, bad, hold);
            for (int k = 0; k < 4; k++) uexp[k] = aud(i_host_usb.sent[k], i_host_usb.width);
        end
    endtask

    task automatic wait_check(input int s, input logic [3:0] m);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_sys);
            #1;
            if (pv === m) break;
        end
        chk("pipeline_valid", {28'h0, m}, {28'h0, pv});
        for (int d = 0; d < 4; d++) begin
            if (route[d] == s) begin
                chk("pipeline sample", s == 17 ? uexp[d] : s == 18 ? iexp[d] : nexp[d],
                    outs[d]);
            end
        end
    endtask

    // ========
    // main sequence
    initial begin
        srst = 1'b1;
        strap = 1'b1;
        nv = 1'b0;
        route_wr = 1'b0;
        route_dest = 3'h0;
        route_src = 5'h00;
        nat = '0;
        void'($urandom(32'h9A1689F9));
        repeat (2) @(posedge clk_sys);
        #1;
        srst = 1'b0;
        @(posedge clk_sys);
        #1;
        strap = 1'b0;
        @(posedge clk_sys);
        #1;
        chk("usb_width_24", 32'h1, {31'h0, w24});
        chk("usb_muted", 32'h1, {31'h0, umute});
        chk("i2s_muted", 32'h1, {31'h0, imute});
        set_routes('{17, 17, 17, 17});
        // single groups, the last with zero reference
        for (int g = 0; g < 3; g++) begin
            grp(1'b0, g == 2, 1'b0, 0);
            wait_check(17, 4'hF);
            chk("usb_muted", 32'h0, {31'h0, umute});
        end
        // four groups back to back
        @(posedge clk_sys);
        #1;
        v0 = vcnt;
        repeat (3) grp(1'b0, 1'b0, 1'b1, 0);
        grp(1'b0, 1'b0, 1'b0, 0);
        wait_check(17, 4'hF);
        @(posedge clk_sys);
        #1;
        chk("group count", 32'h4, 32'(vcnt - v0));
        // corrupted second frame
        v0 = vcnt;
        e0 = ecnt;
        grp(1'b0, 1'b0, 1'b0, 2);
        repeat (3) @(posedge clk_sys);
        #1;
        chk("usb marker errors", 32'h2, 32'(ecnt - e0));
        chk("usb_muted", 32'h1, {31'h0, umute});
        chk("valid pulses", 32'h0, 32'(vcnt - v0));
        for (int d = 0; d < 4; d++) chk("muted sample", 32'h0, outs[d]);
        grp(1'b0, 1'b0, 1'b0, 0);
        wait_check(17, 4'hF);
        // mixed routing changed while running
        set_routes('{17, 17, 18, 0});
        for (int g = 0; g < 2; g++) begin
            grp(1'b1, 1'b0, 1'b0, 0);
            wait_check(18, 4'h4);
            chk("i2s_muted", 32'h0, {31'h0, imute});
        end
        // corrupted first i2s frame: every frame of the group is refused
        e0 = icnt;
        grp(1'b1, 1'b0, 1'b0, 1);
        repeat (3) @(posedge clk_sys);
        #1;
        chk("i2s marker errors", 32'h3, 32'(icnt - e0));
        chk("i2s_muted", 32'h1, {31'h0, imute});
        chk("i2s muted sample", 32'h0, outs[2]);
        grp(1'b0, 1'b0, 1'b0, 0);
        wait_check(17, 4'h3);
        // native pulse is seen right after the edge that samples it
        for (int k = 0; k < 4; k++) nat[k] = $urandom;
        for (int k = 0; k < 4; k++) nexp[k] = nat[k];
        nv = 1'b1;
        wait_check(0, 4'h8);
        nv = 1'b0;
        // second reset with the strap low: 16-bit usb words
        srst = 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        srst = 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        chk("usb_width_24", 32'h0, {31'h0, w24});
        chk("usb_muted", 32'h1, {31'h0, umute});
        i_host_usb.width = 16;
        set_routes('{17, 17, 17, 17});
        grp(1'b0, 1'b0, 1'b0, 0);
        wait_check(17, 4'hF);
        report_and_stop();
    end
endmodule

// *** pviu_chan_if.sv ***
// link between the top and one unpacker
interface pviu_chan_if;
    import pviu_pkg::*;

    logic       frame_valid;   // one stereo frame this cycle
    logic [1:0] marks;         // {left lsb, right lsb}
    logic [SAMPLE_WIDTH-1:0] left;
    logic [SAMPLE_WIDTH-1:0] right;
    pviu_chan_t ch;            // unpacked channels
    logic       ch_valid;      // one pulse per clean group
    logic       muted;
    logic       marker_error;  // one pulse per bad frame

    modport feed (
        output frame_valid,
        output marks,
        output left,
        output right,
        input  ch,
        input  ch_valid,
        input  muted,
        input  marker_error
    );

    modport unpack (
        input  frame_valid,
        input  marks,
        input  left,
        input  right,
        output ch,
        output ch_valid,
        output muted,
        output marker_error
    );
endinterface

// *** pviu_host_model.sv ***
// host model: packs four 16 kHz channels into three stereo link frames
module pviu_host_model #(
    parameter int WIDTH = 24
) (
    input  wire logic  clk_sys,
    output logic       frame_valid,
    output logic [31:0] left,
    output logic [31:0] right
);
    timeunit 1ns;
    timeprecision 100ps;

    int          width = WIDTH;  // word width on the link, 16, 24 or 32
    logic [31:0] sent [4];       // raw words of the two audio frames

    initial begin
        frame_valid = 1'b0;
        left        = 32'h0;
        right       = 32'h0;
    end

    // ========
    // word packing
    // audio copied bit for bit, marker in the lowest bit, spare upper bits junk
    function automatic logic [31:0] pack(input logic [31:0] a, input logic m);
        logic [31:0] msk;
        msk = (width == 32) ? 32'hFFFFFFFF : ((32'h1 << width) - 32'h1);
        return ($urandom & ~msk) | (a & msk & 32'hFFFFFFFE) | {31'h0, m};
    endfunction

    // ========
    // one group: mic pair, reference pair, spare frame; bad selects a corrupted frame
    task automatic send_group(input logic [31:0] a [4], input int bad, input bit hold);
        logic [1:0] mk;
        for (int f = 0; f < 3; f++) begin
            mk = (f == 0) ? 2'h2 : (f == 1) ? 2'h0 : 2'h1;
            if (bad == f + 1) begin
                mk = 2'h3;
            end
            left  = pack((f == 0) ? a[0] : (f == 1) ? a[2] : $urandom, mk[1]);
            right = pack((f == 0) ? a[1] : (f == 1) ? a[3] : $urandom, mk[0]);
            if (f < 2) begin
                sent[2*f]   = left;
                sent[2*f+1] = right;
            end
            frame_valid = 1'b1;
            @(posedge clk_sys);
            #1;
        end
        // released lines show the inverse of the last word
        if (!hold) begin
            frame_valid = 1'b0;
            left        = ~left;
            right       = ~right;
        end
    endtask
endmodule

// *** pviu_pkg.sv ***
// shared constants, types and helpers of the packed vector injection unpacker
package pviu_pkg;

    // ========================================================
    // rates and widths
    localparam int FRAME_RATE_HZ    = 48000;   // stereo link frame rate
    localparam int CHAN_RATE_HZ     = 16000;   // unpacked channel rate
    localparam int FRAMES_PER_GROUP = FRAME_RATE_HZ / CHAN_RATE_HZ;
    localparam int USB_WIDTH_PACKED = 24;      // host-to-device width for packed input
    localparam int USB_WIDTH_PLAIN  = 16;      // default host-to-device width
    localparam int I2S_WIDTH        = 32;      // i2s word is always this wide
    localparam int SAMPLE_WIDTH     = 32;      // left-aligned internal sample
    localparam int NUM_DEST         = 4;

    // ========================================================
    // crossbar codes
    localparam logic [4:0] SRC_NATIVE       = 5'h00;  // live microphones and reference
    localparam logic [4:0] SRC_USB_UNPACKED = 5'h11;  // code 17
    localparam logic [4:0] SRC_I2S_UNPACKED = 5'h12;  // code 18
    localparam logic [2:0] DEST_FIRST       = 3'h4;   // microphone 0 to pipeline
    localparam logic [2:0] DEST_LAST        = 3'h7;   // reference 1 to pipeline

    // channel slots, in destination order
    localparam int CH_MIC0 = 0;
    localparam int CH_MIC1 = 1;
    localparam int CH_REF0 = 2;
    localparam int CH_REF1 = 3;

    // ========================================================
    // marker pairs {left lsb, right lsb} for each frame of a group
    localparam logic [1:0] MARK_FIRST  = 2'h2;
    localparam logic [1:0] MARK_SECOND = 2'h0;
    localparam logic [1:0] MARK_THIRD  = 2'h1;

    // position in the three-frame group
    typedef enum logic [2:0] {
        PH_FIRST  = 3'b001,
        PH_SECOND = 3'b010,
        PH_THIRD  = 3'b100
    } pviu_phase_e;

    typedef logic [3:0][SAMPLE_WIDTH-1:0] pviu_chan_t;

    // ========================================================
    // usb word to left-aligned audio, marker bit dropped
    function automatic logic [SAMPLE_WIDTH-1:0] pviu_usb_audio(
        input logic [SAMPLE_WIDTH-1:0] raw,
        input logic                    wide
    );
        if (wide) begin
            pviu_usb_audio = {raw[USB_WIDTH_PACKED-1:1], 9'h000};
        end else begin
            pviu_usb_audio = {raw[USB_WIDTH_PLAIN-1:1], 17'h00000};
        end
    endfunction

    // i2s word to audio, marker bit dropped
    function automatic logic [SAMPLE_WIDTH-1:0] pviu_i2s_audio(
        input logic [I2S_WIDTH-1:0] raw
    );
        pviu_i2s_audio = {raw[I2S_WIDTH-1:1], 1'b0};
    endfunction

endpackage

// *** pviu_top.sv ***
// packed vector injection: usb and i2s unpackers behind the pipeline input crossbar
//
// How it works
// - A 48 kHz stereo stream is split into four 16 kHz channels, two microphone and two reference, for the pipeline front end.
// - The lowest bit of each word is the frame marker and only the bits above it are kept as audio.
// - A broken marker sequence mutes the unpacked channels instead of passing bad samples on.
// - Packed usb input uses 24-bit words instead of the default 16 at the default 48 kHz rate.
// - Source code 17 on destinations 4 to 7 feeds each one its own unpacked usb channel.
// - Source code 18 on destinations 4 to 7 feeds each one its own unpacked i2s channel.
// - Packed i2s input always uses 32-bit words with no width setting.
// - The crossbar may be rewritten while running but the usb format is fixed at boot.
module pviu_top
    import pviu_pkg::*;
(
    input  wire logic                    clk_sys,
    input  wire logic                    srst,
    input  wire logic                    usb_width_24_strap,
    input  wire logic                    usb_frame_valid,
    input  wire logic [SAMPLE_WIDTH-1:0] usb_left,
    input  wire logic [SAMPLE_WIDTH-1:0] usb_right,
    input  wire logic                    i2s_frame_valid,
    input  wire logic [I2S_WIDTH-1:0]    i2s_left,
    input  wire logic [I2S_WIDTH-1:0]    i2s_right,
    input  wire logic                    native_valid,
    input  wire pviu_chan_t              native_sample,
    input  wire logic                    route_wr,
    input  wire logic [2:0]              route_dest,
    input  wire logic [4:0]              route_src,
    output logic [SAMPLE_WIDTH-1:0]      pipeline_microphone_in_0,
    output logic [SAMPLE_WIDTH-1:0]      pipeline_microphone_in_1,
    output logic [SAMPLE_WIDTH-1:0]      pipeline_reference_in_0,
    output logic [SAMPLE_WIDTH-1:0]      pipeline_reference_in_1,
    output logic [NUM_DEST-1:0]          pipeline_valid,
    output logic                         usb_width_24,
    output logic                         usb_muted,
    output logic                         i2s_muted,
    output logic                         usb_marker_error,
    output logic                         i2s_marker_error
);

    // ========================================================
    // boot-time usb format, caught once after reset release
    logic boot_done;
    logic next_boot_done;
    logic usb_wide;
    logic next_usb_wide;

    always_comb begin
        next_boot_done = 1'b1;
        next_usb_wide  = usb_wide;
        if (!boot_done) begin
            next_usb_wide = usb_width_24_strap;
        end
    end

    // format never changes after the first cycle out of reset
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            boot_done <= 1'b0;
            usb_wide  <= 1'b0;
        end else begin
            boot_done <= next_boot_done;
            usb_wide  <= next_usb_wide;
        end
    end

    // ========================================================
    // unpackers
    pviu_chan_if usb_link ();
    pviu_chan_if i2s_link ();

    // usb audio from the low 24 or 16 bits, marker in bit 0
    assign usb_link.frame_valid = usb_frame_valid;
    assign usb_link.marks       = {usb_left[0], usb_right[0]};
    assign usb_link.left        = pviu_usb_audio(usb_left, usb_wide);
    assign usb_link.right       = pviu_usb_audio(usb_right, usb_wide);

    // i2s words are always full width
    assign i2s_link.frame_valid = i2s_frame_valid;
    assign i2s_link.marks       = {i2s_left[0], i2s_right[0]};
    assign i2s_link.left        = pviu_i2s_audio(i2s_left);
    assign i2s_link.right       = pviu_i2s_audio(i2s_right);

    pviu_unpacker u_usb_unpack (
        .clk_sys (clk_sys),
        .srst    (srst),
        .link    (usb_link.unpack)
    );

    pviu_unpacker u_i2s_unpack (
        .clk_sys (clk_sys),
        .srst    (srst),
        .link    (i2s_link.unpack)
    );

    // ========================================================
    // crossbar table for destinations 4 to 7, writable any time
    logic [NUM_DEST-1:0][4:0] route;
    logic [NUM_DEST-1:0][4:0] next_route;
    logic [2:0]               dest_off;

    always_comb begin
        next_route = route;
        dest_off   = route_dest - DEST_FIRST;
        if (route_wr && route_dest >= DEST_FIRST && route_dest <= DEST_LAST) begin
            next_route[dest_off[1:0]] = route_src;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            route <= {NUM_DEST{SRC_NATIVE}};
        end else begin
            route <= next_route;
        end
    end

    // ========================================================
    // pipeline inputs, each destination takes its own channel slot
    pviu_chan_t          pipe;
    pviu_chan_t          next_pipe;
    logic [NUM_DEST-1:0] pvalid;
    logic [NUM_DEST-1:0] next_pvalid;

    always_comb begin
        next_pipe   = pipe;
        next_pvalid = '0;
        for (int d = 0; d < NUM_DEST; d++) begin
            if (route[d] == SRC_USB_UNPACKED) begin
                if (usb_link.ch_valid || usb_link.muted) begin
                    next_pipe[d] = usb_link.ch[d];
                end
                next_pvalid[d] = usb_link.ch_valid;
            end else if (route[d] == SRC_I2S_UNPACKED) begin
                if (i2s_link.ch_valid || i2s_link.muted) begin
                    next_pipe[d] = i2s_link.ch[d];
                end
                next_pvalid[d] = i2s_link.ch_valid;
            end else if (native_valid) begin
                next_pipe[d]   = native_sample[d];
                next_pvalid[d] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pipe   <= '0;
            pvalid <= '0;
        end else begin
            pipe   <= next_pipe;
            pvalid <= next_pvalid;
        end
    end

    assign pipeline_microphone_in_0 = pipe[CH_MIC0];
    assign pipeline_microphone_in_1 = pipe[CH_MIC1];
    assign pipeline_reference_in_0  = pipe[CH_REF0];
    assign pipeline_reference_in_1  = pipe[CH_REF1];
    assign pipeline_valid           = pvalid;
    assign usb_width_24             = usb_wide;
    assign usb_muted                = usb_link.muted;
    assign i2s_muted                = i2s_link.muted;
    assign usb_marker_error         = usb_link.marker_error;
    assign i2s_marker_error         = i2s_link.marker_error;

    // ========================================================
    // checks
    AST_ROUTE_USB: assert property (@(posedge clk_sys) disable iff (srst)
        route[CH_MIC0] == SRC_USB_UNPACKED && usb_link.ch_valid
        |=> pipeline_valid[CH_MIC0] && pipeline_microphone_in_0 == $past(usb_link.ch[CH_MIC0]))
        else $error("usb channel not routed to microphone 0");

    AST_ROUTE_I2S: assert property (@(posedge clk_sys) disable iff (srst)
        route[CH_REF1] == SRC_I2S_UNPACKED && i2s_link.ch_valid
        |=> pipeline_valid[CH_REF1] && pipeline_reference_in_1 == $past(i2s_link.ch[CH_REF1]))
        else $error("i2s channel not routed to reference 1");

    AST_ROUTE_MUTE: assert property (@(posedge clk_sys) disable iff (srst)
        route[CH_MIC1] == SRC_USB_UNPACKED && usb_link.muted
        |=> pipeline_microphone_in_1 == '0)
        else $error("muted usb source reached the pipeline");

    AST_RUNTIME_ROUTE: assert property (@(posedge clk_sys) disable iff (srst)
        route_wr && route_dest == DEST_FIRST |=> route[CH_MIC0] == $past(route_src))
        else $error("runtime crossbar write lost");

    AST_BOOT_FIXED: assert property (@(posedge clk_sys) disable iff (srst)
        boot_done |=> $stable(usb_width_24))
        else $error("usb format changed at runtime");

    COV_USB_ROUTE: cover property (@(posedge clk_sys) disable iff (srst)
        route[CH_MIC0] == SRC_USB_UNPACKED && pipeline_valid[CH_MIC0]);
    COV_I2S_ROUTE: cover property (@(posedge clk_sys) disable iff (srst)
        route[CH_REF0] == SRC_I2S_UNPACKED && pipeline_valid[CH_REF0]);
    COV_USB_ERROR: cover property (@(posedge clk_sys) disable iff (srst)
        usb_marker_error);

endmodule

// *** pviu_unpacker.sv ***
// three-frame marker checker and four-channel unpacker
module pviu_unpacker
    import pviu_pkg::*;
(
    input wire logic   clk_sys,
    input wire logic   srst,
    pviu_chan_if.unpack link
);

    // ========================================================
    // state
    pviu_phase_e phase;
    pviu_phase_e next_phase;
    pviu_chan_t  stage;
    pviu_chan_t  next_stage;
    pviu_chan_t  chan;
    pviu_chan_t  next_chan;
    logic        valid;
    logic        next_valid;
    logic        muted;
    logic        next_muted;
    logic        err;
    logic        next_err;
    logic        bad;

    // group walk: first frame holds mics, second refs, third is spare
    always_comb begin
        next_phase = phase;
        next_stage = stage;
        next_chan  = chan;
        next_valid = 1'b0;
        next_muted = muted;
        next_err   = 1'b0;
        bad        = 1'b0;
        if (link.frame_valid) begin
            unique case (phase)
                PH_FIRST: begin
                    if (link.marks == MARK_FIRST) begin
                        next_stage[CH_MIC0] = link.left;
                        next_stage[CH_MIC1] = link.right;
                        next_phase = PH_SECOND;
                    end else begin
                        bad = 1'b1;
                    end
                end
                PH_SECOND: begin
                    if (link.marks == MARK_SECOND) begin
                        next_stage[CH_REF0] = link.left;
                        next_stage[CH_REF1] = link.right;
                        next_phase = PH_THIRD;
                    end else begin
                        bad = 1'b1;
                    end
                end
                PH_THIRD: begin
                    if (link.marks == MARK_THIRD) begin
                        next_chan  = stage;
                        next_valid = 1'b1;
                        next_muted = 1'b0;
                        next_phase = PH_FIRST;
                    end else begin
                        bad = 1'b1;
                    end
                end
            endcase
            // bad marker: mute, then resync on a first-frame marker
            if (bad) begin
                next_err   = 1'b1;
                next_muted = 1'b1;
                next_chan  = '0;
                if (link.marks == MARK_FIRST) begin
                    next_stage[CH_MIC0] = link.left;
                    next_stage[CH_MIC1] = link.right;
                    next_phase = PH_SECOND;
                end else begin
                    next_phase = PH_FIRST;
                end
            end
        end
    end

    // registers, muted until the first clean group
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            phase <= PH_FIRST;
            stage <= '0;
            chan  <= '0;
            valid <= 1'b0;
            muted <= 1'b1;
            err   <= 1'b0;
        end else begin
            phase <= next_phase;
            stage <= next_stage;
            chan  <= next_chan;
            valid <= next_valid;
            muted <= next_muted;
            err   <= next_err;
        end
    end

    assign link.ch           = chan;
    assign link.ch_valid     = valid;
    assign link.muted        = muted;
    assign link.marker_error = err;

    // ========================================================
    // checks
    AST_BAD_MUTES: assert property (@(posedge clk_sys) disable iff (srst)
        link.frame_valid && phase == PH_FIRST && link.marks != MARK_FIRST
        |=> link.muted && link.marker_error && link.ch == '0)
        else $error("bad marker did not mute");

    AST_MUTED_SILENT: assert property (@(posedge clk_sys) disable iff (srst)
        link.muted |-> link.ch == '0)
        else $error("muted output carries audio");

    AST_EMIT_CAUSE: assert property (@(posedge clk_sys) disable iff (srst)
        link.ch_valid |-> $past(phase) == PH_THIRD && $past(link.marks) == MARK_THIRD
        && $past(link.frame_valid) && !link.muted)
        else $error("group emitted without third-frame marker");

    AST_EMIT_SPACING: assert property (@(posedge clk_sys) disable iff (srst)
        link.ch_valid |=> !link.ch_valid [*2])
        else $error("groups closer than three frames");

    AST_LSB_DROPPED: assert property (@(posedge clk_sys) disable iff (srst)
        link.ch_valid |-> !link.ch[CH_MIC0][0] && !link.ch[CH_MIC1][0]
        && !link.ch[CH_REF0][0] && !link.ch[CH_REF1][0])
        else $error("marker bit left in audio");

    AST_MIC_STAGED: assert property (@(posedge clk_sys) disable iff (srst)
        link.frame_valid && link.marks == MARK_FIRST && phase != PH_THIRD
        |=> stage[CH_MIC0] == $past(link.left) && stage[CH_MIC1] == $past(link.right))
        else $error("first frame not staged to microphones");

    COV_CLEAN_GROUP: cover property (@(posedge clk_sys) disable iff (srst)
        link.muted ##1 link.ch_valid);
    COV_RESYNC: cover property (@(posedge clk_sys) disable iff (srst)
        link.marker_error ##[1:8] link.ch_valid);

endmodule
